/* hw/uaru_pkg.sv */
// Package of constants and types for the asynchronous serial receiver
package uaru_pkg;

  // Register map, byte offsets on the local register port
  localparam int          ADDR_W      = 3;
  localparam logic [2:0]  OFF_RX_CTRL = 3'h0;
  localparam logic [2:0]  OFF_RX_DATA = 3'h1;
  localparam logic [2:0]  OFF_TX_CTRL = 3'h2;
  localparam logic [2:0]  OFF_BAUD    = 3'h3;
  localparam logic [2:0]  OFF_DIV_LO  = 3'h4;
  localparam logic [2:0]  OFF_DIV_HI  = 3'h5;
  localparam logic [2:0]  OFF_IRQ     = 3'h6;

  // Receive control/status bit positions
  localparam int RC_PORT_EN  = 7;
  localparam int RC_NINE     = 6;
  localparam int RC_SINGLE   = 5;
  localparam int RC_CONT     = 4;
  localparam int RC_ADDR_DET = 3;
  localparam int RC_FRAME    = 2;
  localparam int RC_OVERRUN  = 1;
  localparam int RC_NINTH    = 0;

  // Transmit control/status and baud control bits seen here
  localparam int        TC_SYNC     = 4;
  localparam int        TC_SHIFT_MT = 1;
  localparam int        BC_IDLE     = 6;
  localparam logic [7:0] BC_WR_MASK = 8'h1B;
  localparam logic [7:0] TC_WR_MASK = 8'hFD;

  // Interrupt control bits
  localparam int IC_RX_EN   = 0;
  localparam int IC_PERI_EN = 1;
  localparam int IC_GLOB_EN = 2;
  localparam int IC_PENDING = 3;

  // Bit timing in oversample ticks
  localparam int          OVERSAMPLE = 16;
  localparam logic [3:0]  SMP_FIRST  = 4'h7;
  localparam logic [3:0]  SMP_LAST   = 4'h9;
  localparam logic [3:0]  BITS_EIGHT = 4'h8;
  localparam logic [3:0]  BITS_NINE  = 4'h9;

  // FIFO occupancy
  localparam logic [1:0]  FIFO_FULL  = 2'h2;

  // One received character as it sits in the FIFO
  typedef struct packed {
    logic       frame_err;
    logic       ninth;
    logic [7:0] data;
  } uaru_entry_t;

  // Receive control fields written by software
  typedef struct packed {
    logic port_en;
    logic nine;
    logic single;
    logic cont;
    logic addr_det;
  } uaru_rxctl_t;

endpackage : uaru_pkg

/* hw/uaru_receiver.sv */
// Asynchronous serial receiver with two-entry FIFO and register port
//
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/100ps

module uaru_receiver #(
  parameter int ADDR_W = uaru_pkg::ADDR_W
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              srst,
  // Serial side
  input  wire logic              receive_pin,
  input  wire logic              baud_tick16,
  // Register port
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [7:0]        wr_data,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  output logic [7:0]             rd_data,
  // Status out
  output logic                   rx_pending_flag,
  output logic                   rx_irq
);

  // Elaboration check: every register offset must still decode
  if (ADDR_W < uaru_pkg::ADDR_W) begin : g_addr_chk
    $error("uaru_receiver: ADDR_W too small for register map");
  end

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_START,
    ST_DATA,
    ST_STOP
  } uaru_state_t;

  // Majority of three samples
  function automatic logic maj3(input logic [2:0] s);
    maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction : maj3

  //////////////////////////////////////////////////////////////////////////
  // Registers

  uaru_pkg::uaru_rxctl_t rxctl;
  logic [7:0]            tx_ctrl;
  logic [7:0]            baud_ctrl;
  logic [7:0]            div_lo;
  logic [7:0]            div_hi;
  logic [2:0]            irq_en;
  logic                  overrun;

  uaru_pkg::uaru_entry_t fifo [2];
  logic                  rd_ptr;
  logic                  wr_ptr;
  logic [1:0]            fifo_cnt;

  uaru_state_t           state;
  uaru_state_t           next_state;
  logic [3:0]            tick_cnt;
  logic [3:0]            next_tick_cnt;
  logic [3:0]            bit_cnt;
  logic [3:0]            next_bit_cnt;
  logic [8:0]            shifter;
  logic [8:0]            next_shifter;
  logic [2:0]            samples;
  logic [2:0]            next_samples;
  logic                  rx_last;
  logic                  char_done;
  logic                  stop_level;

  //////////////////////////////////////////////////////////////////////////
  // Decode

  wire sel_rx_ctrl = addr == ADDR_W'(uaru_pkg::OFF_RX_CTRL);
  wire sel_rx_data = addr == ADDR_W'(uaru_pkg::OFF_RX_DATA);
  wire sel_tx_ctrl = addr == ADDR_W'(uaru_pkg::OFF_TX_CTRL);
  wire sel_baud    = addr == ADDR_W'(uaru_pkg::OFF_BAUD);
  wire sel_div_lo  = addr == ADDR_W'(uaru_pkg::OFF_DIV_LO);
  wire sel_div_hi  = addr == ADDR_W'(uaru_pkg::OFF_DIV_HI);
  wire sel_irq     = addr == ADDR_W'(uaru_pkg::OFF_IRQ);

  // Receiver enabled only in asynchronous mode with both enables
  wire sync_mode = tx_ctrl[uaru_pkg::TC_SYNC];
  wire rx_on     = rxctl.port_en & rxctl.cont & ~sync_mode;

  wire fifo_nonempty = fifo_cnt != 2'h0;
  wire uaru_pkg::uaru_entry_t head = fifo[rd_ptr];

  // Oldest entry's flags; an empty FIFO shows zeros
  wire head_framing_error_flag  = fifo_nonempty & head.frame_err;
  wire head_ninth = fifo_nonempty & head.ninth;

  // A data read pops the oldest character
  wire pop = rd_en & sel_rx_data & fifo_nonempty & rxctl.port_en;

  //////////////////////////////////////////////////////////////////////////
  // Character completion and FIFO admission

  // Eight-bit characters end up in the top eight shifter bits
  wire [7:0] char_low  = rxctl.nine ? shifter[7:0] : shifter[8:1];
  wire       char_ninth = rxctl.nine & shifter[8];

  // In nine-bit mode, address detect drops characters whose ninth bit is clear
  wire keep_char = ~(rxctl.nine & rxctl.addr_det) | char_ninth;

  // A read in the same cycle frees a slot before the push lands
  wire fifo_full = (fifo_cnt == uaru_pkg::FIFO_FULL) & ~pop;
  wire push      = char_done & keep_char & ~fifo_full;
  wire ovr_hit   = char_done & keep_char & fifo_full;

  wire uaru_pkg::uaru_entry_t new_entry = '{
    frame_err: ~stop_level,
    ninth:     char_ninth,
    data:      char_low
  };

  wire [1:0] next_fifo_cnt = fifo_cnt + {1'b0, push} - {1'b0, pop};

  // Pending follows occupancy while the receiver is on, not the interrupt enables
  wire next_pending = rx_on & (next_fifo_cnt != 2'h0);
  wire irq_gate     = &irq_en;

  //////////////////////////////////////////////////////////////////////////
  // Read mux

  wire [7:0] rx_ctrl_rd = {
    rxctl.port_en, rxctl.nine, rxctl.single, rxctl.cont,
    rxctl.addr_det, head_framing_error_flag, overrun, head_ninth
  };
  wire [7:0] baud_rd = (baud_ctrl & uaru_pkg::BC_WR_MASK)
                     | ({7'h00, state == ST_IDLE} << uaru_pkg::BC_IDLE);
  wire [7:0] tx_rd   = tx_ctrl | (8'h01 << uaru_pkg::TC_SHIFT_MT);
  wire [7:0] irq_rd  = {4'h0, rx_pending_flag, irq_en};

  wire [7:0] read_mux = sel_rx_ctrl ? rx_ctrl_rd :
                        sel_rx_data ? head.data & {8{fifo_nonempty}} :
                        sel_tx_ctrl ? tx_rd :
                        sel_baud    ? baud_rd :
                        sel_div_lo  ? div_lo :
                        sel_div_hi  ? div_hi :
                        sel_irq     ? irq_rd : 8'h00;

  //////////////////////////////////////////////////////////////////////////
  // Data recovery state machine

  // Majority over the three ticks around the bit centre
  wire vote      = maj3({samples[1:0], receive_pin});
  wire at_centre = baud_tick16 & (tick_cnt == uaru_pkg::SMP_LAST);
  wire in_window = baud_tick16 & (tick_cnt >= uaru_pkg::SMP_FIRST)
                 & (tick_cnt <= uaru_pkg::SMP_LAST);
  wire [3:0] char_bits = rxctl.nine ? uaru_pkg::BITS_NINE
                                    : uaru_pkg::BITS_EIGHT;

  // Sequencer: counter wraps every 16 ticks, so centres stay one bit apart
  always_comb begin
    next_state    = state;
    next_tick_cnt = tick_cnt;
    next_bit_cnt  = bit_cnt;
    next_shifter  = shifter;
    next_samples  = samples;
    char_done     = 1'b0;
    stop_level    = 1'b1;
    if (in_window) begin
      next_samples = {samples[1:0], receive_pin};
    end
    if (baud_tick16 && state != ST_IDLE) begin
      next_tick_cnt = tick_cnt + 4'h1;
    end
    case (state)
      ST_IDLE: begin
        // Overrun blocks new characters until cleared
        if (rx_on && !overrun && rx_last && !receive_pin) begin
          next_state    = ST_START;
          next_tick_cnt = 4'h0;
        end
      end
      ST_START: begin
        if (at_centre) begin
          next_bit_cnt = 4'h0;
          next_state   = vote ? ST_IDLE : ST_DATA;
        end
      end
      ST_DATA: begin
        if (at_centre) begin
          next_shifter = {vote, shifter[8:1]};
          next_bit_cnt = bit_cnt + 4'h1;
          if (bit_cnt + 4'h1 == char_bits) begin
            next_state = ST_STOP;
          end
        end
      end
      ST_STOP: begin
        // Receiver switched off mid-stop must not push or flag overrun
        if (at_centre && rx_on) begin
          char_done  = 1'b1;
          stop_level = vote;
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (!rx_on) begin
      next_state = ST_IDLE;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Sequencer registers; port disable holds everything idle

  always_ff @(posedge clk) begin
    if (srst || !rxctl.port_en) begin
      state    <= ST_IDLE;
      tick_cnt <= 4'h0;
      bit_cnt  <= 4'h0;
      shifter  <= 9'h000;
      samples  <= 3'h7;
      rx_last  <= 1'b1;
    end else begin
      state    <= next_state;
      tick_cnt <= next_tick_cnt;
      bit_cnt  <= next_bit_cnt;
      shifter  <= next_shifter;
      samples  <= next_samples;
      rx_last  <= receive_pin;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // FIFO storage and pointers

  always_ff @(posedge clk) begin
    if (push) begin
      fifo[wr_ptr] <= new_entry;
    end
  end

  // Port disable empties the FIFO, which also clears framing status
  always_ff @(posedge clk) begin
    if (srst || !rxctl.port_en) begin
      rd_ptr   <= 1'b0;
      wr_ptr   <= 1'b0;
      fifo_cnt <= 2'h0;
    end else begin
      rd_ptr   <= rd_ptr ^ pop;
      wr_ptr   <= wr_ptr ^ push;
      fifo_cnt <= next_fifo_cnt;
    end
  end

  // Overrun: set wins; cleared by receive enable or port enable low
  always_ff @(posedge clk) begin
    if (srst) begin
      overrun <= 1'b0;
    end else if (ovr_hit) begin
      overrun <= 1'b1;
    end else if (!rxctl.cont || !rxctl.port_en) begin
      overrun <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Software-written registers

  always_ff @(posedge clk) begin
    if (srst) begin
      rxctl     <= '0;
      tx_ctrl   <= 8'h00;
      baud_ctrl <= 8'h00;
      div_lo    <= 8'h00;
      div_hi    <= 8'h00;
      irq_en    <= 3'h0;
    end else if (wr_en) begin
      if (sel_rx_ctrl) rxctl   <= wr_data[7:3];
      if (sel_tx_ctrl) tx_ctrl <= wr_data & uaru_pkg::TC_WR_MASK;
      if (sel_baud)    baud_ctrl <= wr_data & uaru_pkg::BC_WR_MASK;
      if (sel_div_lo)  div_lo  <= wr_data;
      if (sel_div_hi)  div_hi  <= wr_data;
      if (sel_irq)     irq_en  <= wr_data[2:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs, all registered

  always_ff @(posedge clk) begin
    if (srst) begin
      rd_data         <= 8'h00;
      rx_pending_flag <= 1'b0;
      rx_irq          <= 1'b0;
    end else begin
      rd_data         <= rd_en ? read_mux : 8'h00;
      rx_pending_flag <= next_pending;
      rx_irq          <= next_pending & irq_gate;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks

  pend_flag_a: assert property (
    @(posedge clk) disable iff (srst)
    (rx_on && fifo_nonempty && !pop) |=> rx_pending_flag
  ) else $error("pending flag missing with unread data");

  irq_gate_a: assert property (
    @(posedge clk) disable iff (srst)
    rx_irq |-> rx_pending_flag && $past(irq_en == 3'h7)
  ) else $error("interrupt without all enables");

  read_pop_a: assert property (
    @(posedge clk) disable iff (srst)
    (pop && !push && rxctl.port_en) |=>
      fifo_cnt == $past(fifo_cnt) - 2'h1 && rd_ptr != $past(rd_ptr)
  ) else $error("data read did not pop");

  ovr_set_a: assert property (
    @(posedge clk) disable iff (srst)
    ovr_hit |=> overrun && fifo_cnt == uaru_pkg::FIFO_FULL
              && state == ST_IDLE
  ) else $error("overrun not flagged on full FIFO");

  ovr_clear_a: assert property (
    @(posedge clk) disable iff (srst)
    $fell(overrun) |-> $past(!rxctl.cont || !rxctl.port_en)
  ) else $error("overrun cleared without disable");

  port_reset_a: assert property (
    @(posedge clk) disable iff (srst)
    !rxctl.port_en |=> fifo_cnt == 2'h0 && !head_framing_error_flag
                     && state == ST_IDLE
  ) else $error("port disable did not reset receiver");

  start_abort_a: assert property (
    @(posedge clk) disable iff (srst)
    (state == ST_START && at_centre && vote && rx_on) |=>
      state == ST_IDLE && $stable(overrun) && $stable(wr_ptr)
  ) else $error("false start not abandoned quietly");

  addr_drop_a: assert property (
    @(posedge clk) disable iff (srst)
    (char_done && rxctl.nine && rxctl.addr_det && !shifter[8]
      && rxctl.port_en) |=> wr_ptr == $past(wr_ptr) && !$rose(overrun)
  ) else $error("data character passed address filter");

  fifo_cap_a: assert property (
    @(posedge clk) disable iff (srst)
    fifo_cnt <= uaru_pkg::FIFO_FULL
  ) else $error("FIFO holds more than two characters");

  push_done_a: assert property (
    @(posedge clk) disable iff (srst)
    push |=> fifo_nonempty && rx_pending_flag
  ) else $error("pushed character not pending");

  stop_frame_a: assert property (
    @(posedge clk) disable iff (srst)
    push |=> fifo[$past(wr_ptr)].frame_err == !$past(stop_level)
  ) else $error("framing bit not stored with character");

  ninth_store_a: assert property (
    @(posedge clk) disable iff (srst)
    (push && rxctl.nine) |=> fifo[$past(wr_ptr)].ninth == $past(shifter[8])
  ) else $error("ninth bit not stored with character");

  ovr_block_a: assert property (
    @(posedge clk) disable iff (srst)
    (overrun && rxctl.port_en) |=> state == ST_IDLE && $stable(wr_ptr)
  ) else $error("character accepted during overrun");

  framing_error_flag_hold_a: assert property (
    @(posedge clk) disable iff (srst)
    (!rx_on && rxctl.port_en && !pop) |=> $stable(head_framing_error_flag)
  ) else $error("framing status moved with receiver off");

endmodule : uaru_receiver

/* sim/tb_async_uart_receiver.sv */
// Self-checking bench for the serial receiver
`timescale 1ns/100ps

module tb_async_uart_receiver;
  logic       clk, srst, go, mnine, mstop, glitch;
  logic       tick = 1'b0;
  logic       wr_en, rd_en, m_line, m_busy, pend, irq, rx_pin;
  logic [2:0] addr;
  logic [7:0] wr_data, rd_data, v, rv;
  logic [8:0] mdata, d0, d1, d2;
  logic [1:0] tcnt = 2'h0;
  logic [2:0] ra [4] = '{3'h0, 3'h1, 3'h6, 3'h7};
  int         fails = 0;
  int         compares = 0;

  uaru_receiver DUT (
    .clk             (clk),
    .srst            (srst),
    .receive_pin     (rx_pin),
    .baud_tick16     (tick),
    .addr            (addr),
    .wr_data         (wr_data),
    .wr_en           (wr_en),
    .rd_en           (rd_en),
    .rd_data         (rd_data),
    .rx_pending_flag (pend),
    .rx_irq          (irq)
  );

  uaru_line_model FAR (
    .clk      (clk),
    .tick     (tick),
    .go       (go),
    .data     (mdata),
    .nine     (mnine),
    .stop_bit (mstop),
    .line     (m_line),
    .busy     (m_busy)
  );

  // A held-low glitch overrides the line to fake a short start
  assign rx_pin = m_line & ~glitch;

  // Baud strobe every four clocks keeps an eight-bit frame at 640 clocks
  always @(posedge clk) begin
    tcnt <= tcnt + 2'h1;
    tick <= (tcnt == 2'h3);
  end

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  function automatic logic irq_exp(input logic [2:0] en, input logic p);
    return (&en) & p;
  endfunction : irq_exp

  task automatic tally_and_finish();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string what, input logic [8:0] seen,
                     input logic [8:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge clk);
    wr_en   <= 1'b0;
  endtask : wr

  // Read data is valid only in the cycle after the strobe
  task automatic rdc(input string what, input logic [2:0] a,
                     input logic [7:0] m, input logic [7:0] e);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    v = rd_data;
    chk(what, 9'(v & m), 9'(e));
  endtask : rdc

  task automatic pchk(input logic e);
    repeat (2) @(posedge clk);
    #1;
    chk("pending", 9'(pend), 9'(e));
  endtask : pchk

  // Whole frame, then a few clocks for the push to land
  task automatic send(input logic [8:0] d, input logic n9, input logic sb);
    @(posedge clk);
    mdata <= d;
    mnine <= n9;
    mstop <= sb;
    go    <= 1'b1;
    @(posedge clk);
    go    <= 1'b0;
    #1;
    for (int i = 0; i < 1000 && m_busy !== 1'b0; i++) @(posedge clk);
    repeat (4) @(posedge clk);
    #1;
  endtask : send

  // Bounded run; a hang ends as a mismatch
  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    tally_and_finish();
  end

  initial begin
    srst = 1'b1; addr = 3'h0; wr_data = 8'h00; wr_en = 1'b0;
    rd_en = 1'b0; go = 1'b0; mdata = 9'h000; mnine = 1'b0;
    mstop = 1'b1; glitch = 1'b0;
    void'($urandom(55));
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    foreach (ra[i]) rdc("reset read", ra[i], 8'hff, 8'h00);
    $display("test reset done");
    // Divisors are plain storage; the rate itself comes from the strobe
    rv = 8'($urandom);
    wr(3'h4, rv);
    wr(3'h5, ~rv);
    rdc("divisor lo", 3'h4, 8'hff, rv);
    rdc("divisor hi", 3'h5, 8'hff, ~rv);
    rdc("rx idle", 3'h3, 8'h40, 8'h40);
    wr(3'h2, 8'h00);
    wr(3'h0, 8'h90);
    wr(3'h6, 8'h07);
    d0 = {1'b0, 8'($urandom)};
    send(d0, 1'b0, 1'b1);
    chk("pending", 9'(pend), 9'h001);
    chk("irq", 9'(irq), 9'(irq_exp(3'h7, 1'b1)));
    rdc("status", 3'h0, 8'h07, 8'h00);
    rdc("data", 3'h1, 8'hff, d0[7:0]);
    pchk(1'b0);
    $display("test basic done");
    send(d0, 1'b0, 1'b1);
    for (int i = 0; i < 8; i++) begin
      wr(3'h6, 8'(i) | 8'h08);
      pchk(1'b1);
      chk("irq", 9'(irq), 9'(irq_exp(3'(i), 1'b1)));
    end
    rdc("data", 3'h1, 8'hff, d0[7:0]);
    wr(3'h6, 8'h0f);
    rdc("irq reg", 3'h6, 8'h0f, 8'h07);
    $display("test irq done");
    d1 = {1'b0, 8'($urandom)};
    send(d0, 1'b0, 1'b0);
    send(d1, 1'b0, 1'b1);
    rdc("status", 3'h0, 8'h07, 8'h04);
    rdc("data", 3'h1, 8'hff, d0[7:0]);
    rdc("status", 3'h0, 8'h07, 8'h00);
    rdc("data", 3'h1, 8'hff, d1[7:0]);
    send(d0, 1'b0, 1'b0);
    wr(3'h0, 8'h80);
    rdc("status", 3'h0, 8'h07, 8'h04);
    pchk(1'b0);
    wr(3'h0, 8'h00);
    rdc("status", 3'h0, 8'h07, 8'h00);
    wr(3'h0, 8'h90);
    pchk(1'b0);
    $display("test framing done");
    d2 = {1'b0, 8'($urandom)};
    send(d0, 1'b0, 1'b1);
    send(d1, 1'b0, 1'b1);
    send(d2, 1'b0, 1'b1);
    rdc("status", 3'h0, 8'h07, 8'h02);
    send(d2, 1'b0, 1'b1);
    rdc("data", 3'h1, 8'hff, d0[7:0]);
    rdc("data", 3'h1, 8'hff, d1[7:0]);
    pchk(1'b0);
    // Software drops receive enable to lift the overrun
    wr(3'h0, 8'h80);
    rdc("status", 3'h0, 8'h07, 8'h00);
    wr(3'h0, 8'h90);
    send(d2, 1'b0, 1'b1);
    rdc("data", 3'h1, 8'hff, d2[7:0]);
    $display("test overrun done");
    @(posedge clk);
    glitch <= 1'b1;
    repeat (24) @(posedge clk);
    glitch <= 1'b0;
    repeat (800) @(posedge clk);
    pchk(1'b0);
    rdc("status", 3'h0, 8'h07, 8'h00);
    send(d1, 1'b0, 1'b1);
    rdc("data", 3'h1, 8'hff, d1[7:0]);
    $display("test false start done");
    wr(3'h0, 8'hd0);
    d0 = {1'b1, 8'($urandom)};
    send(d0, 1'b1, 1'b1);
    send(d1, 1'b1, 1'b1);
    rdc("ninth", 3'h0, 8'h07, 8'h01);
    rdc("data", 3'h1, 8'hff, d0[7:0]);
    rdc("ninth", 3'h0, 8'h07, 8'h00);
    rdc("data", 3'h1, 8'hff, d1[7:0]);
    wr(3'h0, 8'hd8);
    send(d1, 1'b1, 1'b1);
    pchk(1'b0);
    send(d0, 1'b1, 1'b1);
    pchk(1'b1);
    rdc("data", 3'h1, 8'hff, d0[7:0]);
    // Address matched: open up for the message body
    wr(3'h0, 8'hd0);
    send(d1, 1'b1, 1'b1);
    rdc("data", 3'h1, 8'hff, d1[7:0]);
    $display("test nine bit done");
    wr(3'h0, 8'h90);
    wr(3'h2, 8'h10);
    send(d0, 1'b0, 1'b1);
    pchk(1'b0);
    wr(3'h2, 8'h00);
    send(d1, 1'b0, 1'b1);
    pchk(1'b1);
    rdc("data", 3'h1, 8'hff, d1[7:0]);
    $display("test sync mode done");
    tally_and_finish();
  end
endmodule : tb_async_uart_receiver

/* sim/uaru_line_model.sv */
// Behavioural remote serial transmitter driving the receive line
`timescale 1ns/100ps

module uaru_line_model (
  // Clock and sixteen-per-bit strobe
  input  wire logic       clk,
  input  wire logic       tick,
  // Frame request
  input  wire logic       go,
  input  wire logic [8:0] data,
  input  wire logic       nine,
  input  wire logic       stop_bit,
  // Line side
  output logic            line,
  output logic            busy
);
  logic [10:0] frame;
  logic [3:0]  left;
  logic [3:0]  sub;

  initial begin
    frame = 11'h7ff;
    left  = 4'h0;
    sub   = 4'h0;
    busy  = 1'b0;
  end

  // Start low, data LSB first, stop last, 16 ticks per bit
  always @(posedge clk) begin
    if (go && !busy) begin
      frame <= nine ? {stop_bit, data, 1'b0}
                    : {1'b1, stop_bit, data[7:0], 1'b0};
      left  <= nine ? 4'hb : 4'ha;
      sub   <= 4'h0;
      busy  <= 1'b1;
    end else if (busy && tick) begin
      sub <= sub + 4'h1;
      if (sub == 4'hf) begin
        frame <= {1'b1, frame[10:1]};
        left  <= left - 4'h1;
        busy  <= (left != 4'h1);
      end
    end
  end

  // Line idles high between frames
  assign line = busy ? frame[0] : 1'b1;
endmodule : uaru_line_model
